// File: verilog/gauge_regs_pkg.sv
/*
  Constants and carrier types for the gauge status/control register bank.
  Assumes a 40 MHz system clock and measurement values that are already in
  the system clock domain.
*/
package gauge_regs_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS    = 8'h01;
  localparam logic [7:0] ADDR_SPECIAL   = 8'h15;
  localparam logic [7:0] ADDR_CONTROL   = 8'h60;
  localparam logic [7:0] ADDR_SLAVE     = 8'h7E;

  // Status bit positions
  localparam int BIT_CHARGE_FULL  = 7;
  localparam int BIT_ACTIVE_EMPTY = 6;
  localparam int BIT_STANDBY_EMPTY = 5;
  localparam int BIT_CAL_CYCLE    = 4;
  localparam int BIT_UNDERVOLTAGE = 2;
  localparam int BIT_POWER_ON     = 1;
  // Control bit positions
  localparam int BIT_LOW_V_SLEEP  = 6;
  localparam int BIT_BUS_SLEEP    = 5;
  // Special feature bit positions
  localparam int BIT_ADDR_WE      = 1;
  localparam int BIT_PIN          = 0;

  // Reset values
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h34; // Arbitrary default
  localparam logic       PIN_RESET       = 1'b1;
  localparam logic       ADDR_WE_RESET   = 1'b0;

  // Capacity thresholds in percent
  localparam logic [7:0] PCT_FULL_CLEAR    = 8'h5A;  // 90
  localparam logic [7:0] PCT_AE_CLEAR      = 8'h05;  // 5
  localparam logic [7:0] PCT_SE_SET        = 8'h0A;  // 10
  localparam logic [7:0] PCT_SE_CLEAR      = 8'h0F;  // 15
  // Current reading that stands for +100 uV across the sense resistor
  localparam logic signed [15:0] CURRENT_LOW_LIMIT = 16'sh0040;

  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SLEEP_DELAY_US = 2000;
  localparam int SLEEP_CYCLES =
    (SLEEP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic signed [15:0] voltage_reading;
    logic signed [15:0] input_voltage;
    logic signed [15:0] current_reading;
    logic signed [15:0] average_current;
    logic signed [15:0] accumulated_charge;
    logic [7:0]         active_relative_capacity;
    logic [7:0]         standby_relative_capacity;
  } meas_type;

  typedef struct packed {
    logic signed [15:0] charge_voltage_threshold;
    logic signed [15:0] min_charge_current;
    logic signed [15:0] active_empty_voltage;
    logic signed [15:0] active_empty_current;
    logic signed [15:0] sleep_voltage_threshold;
  } thresh_type;

  typedef struct packed {
    logic voltage_reading_update;
    logic current_update;
    logic avg_update;
    logic acr_load;
  } event_type;

endpackage

// File: verilog/gauge_status_control_regs.sv
/*
  Status, control and special-feature registers of a fuel gauge, with the
  two-wire serial slave that reaches them and the sleep-entry logic.
  Assumes measurement results, thresholds and update strobes come from logic
  on clk_sys_in; the bus lines and the general-purpose pin come from outside
  and are synchronised here.
*/
`timescale 1ns/1ps

// Overview of operation
// - Set charge-full when voltage_reading above threshold, 0<avg<min over an avg interval.
// - Clear charge-full when active relative capacity drops below 90 percent.
// - Set active-empty when voltage_reading below threshold; clear above 5 percent.
// - Standby-empty sets below 10 percent, clears above 15 percent.
// - Set cal-cycle flag on voltage_reading falling below active-empty with heavy discharge.
// - Clear cal flag on full, low current, charge load, or sleep.
// - Clear cal flag when charge reaches zero after voltage_reading fell below threshold.
// - The four gauge flags ignore host writes.
// - Set undervoltage flag when voltage_reading below sleep threshold; host clears it.
// - Power-on flag sets at power-up and holds until host clears it.
// - Control loads from nonvolatile copy at power-up; saved on copy command.
// - Low-voltage enable: sleep when input low and bus stable for delay.
// - Bus-idle enable: sleep when both bus lines low for delay.
// - Slave address writes accepted only while address write enable is 1.
// - Reading pin bit returns sensed level of general-purpose pin.
// - Pin bit 0 drives pin low; 1 releases the open-drain driver.
// - Pin bit forced to 1 at power-up and on sleep entry.
module gauge_status_control_regs #(
  parameter int SLEEP_CYCLES = gauge_regs_pkg::SLEEP_CYCLES
) (
  input  wire logic                   clk_sys_in,
  input  wire logic                   rst_in,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_out,
  input  wire logic                   general_purpose_pin_in,
  output logic                        general_purpose_pin_out,
  output logic                        general_purpose_pin_oe_out,
  input  wire gauge_regs_pkg::meas_type   meas_in,
  input  wire gauge_regs_pkg::thresh_type thresh_in,
  input  wire gauge_regs_pkg::event_type  event_in,
  input  wire logic [7:0]             control_nv_in,
  input  wire logic                   copy_cmd_in,
  output logic [7:0]                  control_nv_out,
  output logic                        sleep_out,
  output logic [7:0]                  status_out,
  output logic [7:0]                  control_out,
  output logic [6:0]                  slave_addr_out
);

  typedef enum logic [3:0] {
    BUS_IDLE, BUS_ADDR, BUS_ADDR_ACK, BUS_PTR, BUS_PTR_ACK,
    BUS_WDATA, BUS_WDATA_ACK, BUS_RDATA, BUS_RDATA_ACK
  } bus_state_type;

  // Synchronisers and edge history
  logic [1:0] scl_sync_q, sda_sync_q, pin_sync_q;
  logic       scl_prev_q, sda_prev_q;
  always_ff @(posedge clk_sys_in)
  begin
    scl_sync_q <= {scl_sync_q[0], scl_in};
    sda_sync_q <= {sda_sync_q[0], sda_in};
    pin_sync_q <= {pin_sync_q[0], general_purpose_pin_in};
    scl_prev_q <= scl_sync_q[1];
    sda_prev_q <= sda_sync_q[1];
  end

  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop, bus_change;
  assign scl_s      = scl_sync_q[1];
  assign sda_s      = sda_sync_q[1];
  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  assign bus_start  = scl_s & scl_prev_q & ~sda_s & sda_prev_q;
  assign bus_stop   = scl_s & scl_prev_q & sda_s & ~sda_prev_q;
  assign bus_change = (scl_s != scl_prev_q) | (sda_s != sda_prev_q);

  // Register state
  logic [7:0] status_q, status_d;
  logic [7:0] control_q, control_d, nv_q, nv_d;
  logic       loaded_q, loaded_d;
  logic       addr_we_q, addr_we_d, pin_q, pin_d;
  logic [6:0] slave_q, slave_d;
  logic       full_run_q, full_run_d, below_q, below_d, above_q, above_d;
  logic [1:0] heavy_q, heavy_d;
  logic       sleep_q, sleep_d;
  logic [31:0] sleep_cnt_q, sleep_cnt_d;

  // Bus state
  bus_state_type state_q, state_d;
  logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
  logic [3:0] bit_q, bit_d;
  logic       rw_q, rw_d, drive_q, drive_d, wr_en;
  logic [7:0] rd_data;

  always_comb
  begin
    case (ptr_q)
      gauge_regs_pkg::ADDR_STATUS:  rd_data = status_q;
      gauge_regs_pkg::ADDR_SPECIAL: rd_data = {6'h00, addr_we_q,
                                               pin_sync_q[1]};
      gauge_regs_pkg::ADDR_CONTROL: rd_data = control_q;
      gauge_regs_pkg::ADDR_SLAVE:   rd_data = {slave_q, 1'b0};
      default:                      rd_data = 8'h00;
    endcase
  end

  // Two-wire slave: address, then pointer and write bytes, or read bytes from the pointer
  always_comb
  begin
    state_d = state_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    bit_d   = bit_q;
    rw_d    = rw_q;
    drive_d = drive_q;
    wr_en   = 1'b0;
    if (bus_stop || sleep_q)
    begin
      state_d = BUS_IDLE;
      drive_d = 1'b0;
    end
    else if (bus_start)
    begin
      state_d = BUS_ADDR;
      bit_d   = 4'h0;
      drive_d = 1'b0;
    end
    else if (scl_rise && (state_q == BUS_ADDR || state_q == BUS_PTR ||
                          state_q == BUS_WDATA))
    begin
      shift_d = {shift_q[6:0], sda_s};
      bit_d   = bit_q + 4'h1;
    end
    else if (scl_rise && state_q == BUS_RDATA_ACK && sda_s)
      state_d = BUS_IDLE;
    else if (scl_fall)
    begin
      case (state_q)
        BUS_ADDR:
          if (bit_q == 4'h8)
          begin
            if (shift_q[7:1] == slave_q)
            begin
              rw_d    = shift_q[0];
              state_d = BUS_ADDR_ACK;
              drive_d = 1'b1;
            end
            else
              state_d = BUS_IDLE;
          end
        BUS_PTR, BUS_WDATA:
          if (bit_q == 4'h8)
          begin
            state_d = (state_q == BUS_PTR) ? BUS_PTR_ACK : BUS_WDATA_ACK;
            drive_d = 1'b1;
            if (state_q == BUS_PTR)
              ptr_d = shift_q;
            else
              wr_en = 1'b1;
          end
        BUS_ADDR_ACK, BUS_RDATA_ACK:
          if (rw_q)
          begin
            state_d = BUS_RDATA;
            shift_d = rd_data;
            bit_d   = 4'h0;
            drive_d = ~rd_data[7];
          end
          else
          begin
            state_d = BUS_PTR;
            bit_d   = 4'h0;
            drive_d = 1'b0;
          end
        BUS_PTR_ACK, BUS_WDATA_ACK:
        begin
          state_d = BUS_WDATA;
          bit_d   = 4'h0;
          drive_d = 1'b0;
          if (state_q == BUS_WDATA_ACK)
            ptr_d = ptr_q + 8'h01;
        end
        BUS_RDATA:
          if (bit_q == 4'h7)
          begin
            state_d = BUS_RDATA_ACK;
            drive_d = 1'b0;
            ptr_d   = ptr_q + 8'h01;
          end
          else
          begin
            shift_d = {shift_q[6:0], 1'b0};
            bit_d   = bit_q + 4'h1;
            drive_d = ~shift_q[6];
          end
        default: state_d = BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_q <= BUS_IDLE;
      shift_q <= 8'h00;
      ptr_q   <= 8'h00;
      bit_q   <= 4'h0;
      rw_q    <= 1'b0;
      drive_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      bit_q   <= bit_d;
      rw_q    <= rw_d;
      drive_q <= drive_d;
    end
  end

  // Gauge flags, control, special feature and sleep
  logic full_cond, heavy_now, below_vae, sleep_cond, cal_clear, wr_status;
  always_comb
  begin
    full_cond = (meas_in.voltage_reading > thresh_in.charge_voltage_threshold)
              && (meas_in.average_current > 16'sh0000)
              && (meas_in.average_current < thresh_in.min_charge_current);
    heavy_now = meas_in.current_reading < -thresh_in.active_empty_current;
    below_vae = meas_in.voltage_reading < thresh_in.active_empty_voltage;
    wr_status = wr_en && ptr_q == gauge_regs_pkg::ADDR_STATUS;
    status_d   = status_q;
    control_d  = control_q;
    nv_d       = nv_q;
    loaded_d   = 1'b1;
    addr_we_d  = addr_we_q;
    pin_d      = pin_q;
    slave_d    = slave_q;
    full_run_d = full_run_q;
    heavy_d    = heavy_q;
    below_d    = below_q;
    above_d    = above_q;
    sleep_d    = sleep_q;
    sleep_cnt_d = sleep_cnt_q;

    if (!loaded_q)
    begin
      control_d = control_nv_in;
      nv_d      = control_nv_in;
    end
    if (copy_cmd_in)
      nv_d = control_q;

    // Host writes; the four gauge flags take none of the written bits
    if (wr_status)
    begin
      if (!shift_q[gauge_regs_pkg::BIT_UNDERVOLTAGE])
        status_d[gauge_regs_pkg::BIT_UNDERVOLTAGE] = 1'b0;
      if (!shift_q[gauge_regs_pkg::BIT_POWER_ON])
        status_d[gauge_regs_pkg::BIT_POWER_ON] = 1'b0;
    end
    if (wr_en && ptr_q == gauge_regs_pkg::ADDR_CONTROL)
      control_d = shift_q;
    if (wr_en && ptr_q == gauge_regs_pkg::ADDR_SPECIAL)
    begin
      addr_we_d = shift_q[gauge_regs_pkg::BIT_ADDR_WE];
      pin_d     = shift_q[gauge_regs_pkg::BIT_PIN];
    end
    if (wr_en && ptr_q == gauge_regs_pkg::ADDR_SLAVE && addr_we_q)
      slave_d = shift_q[7:1];

    // Full detect across one average-current interval
    if (event_in.avg_update)
      full_run_d = full_cond;
    else if (!full_cond)
      full_run_d = 1'b0;
    if (meas_in.active_relative_capacity < gauge_regs_pkg::PCT_FULL_CLEAR)
      status_d[gauge_regs_pkg::BIT_CHARGE_FULL] = 1'b0;
    if (event_in.avg_update && full_run_q && full_cond)
      status_d[gauge_regs_pkg::BIT_CHARGE_FULL] = 1'b1;

    if (meas_in.active_relative_capacity > gauge_regs_pkg::PCT_AE_CLEAR)
      status_d[gauge_regs_pkg::BIT_ACTIVE_EMPTY] = 1'b0;
    if (below_vae)
      status_d[gauge_regs_pkg::BIT_ACTIVE_EMPTY] = 1'b1;

    if (meas_in.standby_relative_capacity > gauge_regs_pkg::PCT_SE_CLEAR)
      status_d[gauge_regs_pkg::BIT_STANDBY_EMPTY] = 1'b0;
    if (meas_in.standby_relative_capacity < gauge_regs_pkg::PCT_SE_SET)
      status_d[gauge_regs_pkg::BIT_STANDBY_EMPTY] = 1'b1;

    if (below_vae)
      below_d = 1'b1;
    if (event_in.current_update)
      heavy_d = {heavy_q[0], heavy_now};
    if (event_in.voltage_reading_update)
      above_d = ~below_vae;
    cal_clear = status_q[gauge_regs_pkg::BIT_CHARGE_FULL]
             || meas_in.current_reading < gauge_regs_pkg::CURRENT_LOW_LIMIT
             || event_in.acr_load
             || (sleep_d && !sleep_q);
    if (below_q && meas_in.accumulated_charge == 16'sh0000)
      cal_clear = 1'b1;
    if (cal_clear)
    begin
      status_d[gauge_regs_pkg::BIT_CAL_CYCLE] = 1'b0;
      below_d = 1'b0;
    end
    if (event_in.voltage_reading_update && above_q && below_vae && (&heavy_q))
    begin
      status_d[gauge_regs_pkg::BIT_CAL_CYCLE] = 1'b1;
      below_d = 1'b1;
    end

    if (meas_in.voltage_reading < thresh_in.sleep_voltage_threshold)
      status_d[gauge_regs_pkg::BIT_UNDERVOLTAGE] = 1'b1;

    // Sleep entry after the bus lines stay unchanged for the delay
    sleep_cond =
      (control_q[gauge_regs_pkg::BIT_LOW_V_SLEEP] &&
       meas_in.input_voltage < thresh_in.sleep_voltage_threshold) ||
      (control_q[gauge_regs_pkg::BIT_BUS_SLEEP] && !scl_s && !sda_s);
    if (sleep_q)
    begin
      sleep_cnt_d = 32'h0000_0000;
      if (bus_change)
        sleep_d = 1'b0;
    end
    else if (!sleep_cond || bus_change)
      sleep_cnt_d = 32'h0000_0000;
    else if (sleep_cnt_q >= 32'(SLEEP_CYCLES - 1))
      sleep_d = 1'b1;
    else
      sleep_cnt_d = sleep_cnt_q + 32'h0000_0001;
    if (sleep_d && !sleep_q)
    begin
      pin_d = 1'b1;
      status_d[gauge_regs_pkg::BIT_CAL_CYCLE] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      status_q    <= 8'h02;
      control_q   <= gauge_regs_pkg::CONTROL_RESET;
      nv_q        <= gauge_regs_pkg::CONTROL_RESET;
      loaded_q    <= 1'b0;
      addr_we_q   <= gauge_regs_pkg::ADDR_WE_RESET;
      pin_q       <= gauge_regs_pkg::PIN_RESET;
      slave_q     <= gauge_regs_pkg::SLAVE_ADDR_RESET;
      full_run_q  <= 1'b0;
      heavy_q     <= 2'h0;
      below_q     <= 1'b0;
      above_q     <= 1'b0;
      sleep_q     <= 1'b0;
      sleep_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      status_q    <= status_d;
      control_q   <= control_d;
      nv_q        <= nv_d;
      loaded_q    <= loaded_d;
      addr_we_q   <= addr_we_d;
      pin_q       <= pin_d;
      slave_q     <= slave_d;
      full_run_q  <= full_run_d;
      heavy_q     <= heavy_d;
      below_q     <= below_d;
      above_q     <= above_d;
      sleep_q     <= sleep_d;
      sleep_cnt_q <= sleep_cnt_d;
    end
  end

  assign sda_out                    = 1'b0;
  assign sda_oe_out                 = drive_q;
  assign general_purpose_pin_out    = 1'b0;
  assign general_purpose_pin_oe_out = ~pin_q;
  assign control_nv_out             = nv_q;
  assign sleep_out                  = sleep_q;
  assign status_out                 = status_q;
  assign control_out                = control_q;
  assign slave_addr_out             = slave_q;

endmodule // gauge_status_control_regs

// File: dv/gauge_regs_checker.sv
/*
  Concurrent checks on the ports of the gauge register bank.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module gauge_regs_checker #(
  parameter int SLEEP_CYCLES = 20
) (
  input wire logic                       clk_sys_in,
  input wire logic                       rst_in,
  input wire logic                       scl_in,
  input wire logic                       sda_in,
  input wire logic                       general_purpose_pin_out,
  input wire logic                       general_purpose_pin_oe_out,
  input wire gauge_regs_pkg::meas_type   meas_in,
  input wire gauge_regs_pkg::thresh_type thresh_in,
  input wire gauge_regs_pkg::event_type  event_in,
  input wire logic [7:0]                 control_nv_in,
  input wire logic                       copy_cmd_in,
  input wire logic [7:0]                 control_nv_out,
  input wire logic                       sleep_out,
  input wire logic [7:0]                 status_out,
  input wire logic [7:0]                 control_out
);
  int lo_cnt_q;
  int lo_cnt_d;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // Counts cycles with both bus lines low while bus-idle sleep is enabled
  always_comb
  begin
    lo_cnt_d = 0;
    if (control_out[5] && !scl_in && !sda_in)
      lo_cnt_d = (lo_cnt_q < 1000) ? lo_cnt_q + 1 : lo_cnt_q;
  end
  always_ff @(posedge clk_sys_in)
    lo_cnt_q <= rst_in ? 0 : lo_cnt_d;
  a_pin_open_drain: assert property (
    !general_purpose_pin_out && (sleep_out -> !general_purpose_pin_oe_out))
    else $error("pin driven while asleep or output not low");
  a_sleep_pin_release: assert property (
    $rose(sleep_out) |-> ##[0:1] !general_purpose_pin_oe_out)
    else $error("pin driver not released on sleep");
  a_sleep_cal_clear: assert property (
    $rose(sleep_out) |-> ##[0:1] !status_out[4])
    else $error("cal flag kept on sleep");
  a_ae_set: assert property (
    meas_in.voltage_reading < thresh_in.active_empty_voltage
    |=> status_out[6])
    else $error("active-empty flag not set");
  a_ae_clear: assert property (
    meas_in.active_relative_capacity > 8'h05 &&
    meas_in.voltage_reading >= thresh_in.active_empty_voltage
    |=> !status_out[6])
    else $error("active-empty flag not cleared");
  a_se_set: assert property (
    meas_in.standby_relative_capacity < 8'h0A |=> status_out[5])
    else $error("standby-empty flag not set");
  a_se_hysteresis: assert property (
    status_out[5] && meas_in.standby_relative_capacity <= 8'h0F
    |=> status_out[5])
    else $error("standby-empty flag lost inside band");
  a_full_clear: assert property (
    meas_in.active_relative_capacity < 8'h5A && !event_in.avg_update
    |=> !status_out[7])
    else $error("charge-full flag not cleared");
  a_uv_set: assert property (
    meas_in.voltage_reading < thresh_in.sleep_voltage_threshold
    |=> status_out[2])
    else $error("undervoltage flag not set");
  a_por_hold: assert property (
    scl_in [*6] ##0 status_out[1] |=> status_out[1])
    else $error("power-on flag lost without host write");
  a_ctrl_load: assert property (
    $fell(rst_in) |=> control_out == $past(control_nv_in))
    else $error("control not loaded from stored copy");
  a_copy_save: assert property (
    copy_cmd_in |=> control_nv_out == $past(control_out))
    else $error("copy command did not save control");
  a_idle_sleep: assert property (
    lo_cnt_q > SLEEP_CYCLES + 8 |-> sleep_out)
    else $error("no sleep with bus held low");
  a_no_sleep: assert property (
    !control_out[5] && !control_out[6] && !sleep_out |=> !sleep_out)
    else $error("sleep entered while disabled");
endmodule // gauge_regs_checker

bind gauge_status_control_regs gauge_regs_checker #(
  .SLEEP_CYCLES(SLEEP_CYCLES)
) u_checker (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_in(sda_in), .general_purpose_pin_out(general_purpose_pin_out),
  .general_purpose_pin_oe_out(general_purpose_pin_oe_out),
  .meas_in(meas_in), .thresh_in(thresh_in), .event_in(event_in),
  .control_nv_in(control_nv_in), .copy_cmd_in(copy_cmd_in),
  .control_nv_out(control_nv_out), .sleep_out(sleep_out),
  .status_out(status_out), .control_out(control_out));

// File: dv/host_master.sv
/*
  Behavioural host controller on the two-wire bus.
  Assumes a pull-up on the data line; 1 on sda_out releases it.
*/
`timescale 1ns/1ps
module host_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic [6:0] dev_addr = 7'h34;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // Quarter of a 200 ns bus clock period
  task automatic qtr();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic lines(input logic c, input logic d);
    scl_out = c;
    qtr();
    qtr();
    sda_out = d;
    qtr();
    qtr();
  endtask
  task automatic start();
    sda_out = 1'b1;
    qtr();
    lines(1'b1, 1'b0);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    qtr();
    sda_out = 1'b0;
    qtr();
    lines(1'b1, 1'b1);
  endtask
  task automatic bit_io(input logic b, output logic r);
    qtr();
    sda_out = b;
    qtr();
    scl_out = 1'b1;
    qtr();
    qtr();
    r = sda_in;
    scl_out = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r[i]);
    bit_io(last, a);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           output logic nack);
    logic [7:0] r;
    logic k1, k2, k3;
    start();
    xfer({dev_addr, 1'b0}, 1'b1, r, k1);
    xfer(a, 1'b1, r, k2);
    xfer(d, 1'b1, r, k3);
    stop();
    nack = k1 | k2 | k3;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    logic [7:0] r;
    logic k;
    start();
    xfer({dev_addr, 1'b0}, 1'b1, r, k);
    xfer(a, 1'b1, r, k);
    start();
    xfer({dev_addr, 1'b1}, 1'b1, r, k);
    xfer(8'hFF, 1'b1, q, k);
    stop();
  endtask
endmodule // host_master

// File: dv/tb_gauge_status_control_regs.sv
/*
  Self-checking bench for the gauge register bank, host on the bus.
  Assumes the checker is bound by its own file.
*/
`timescale 1ns/1ps
module tb_gauge_status_control_regs;
  logic                       clk_sys_in = 1'b0;
  logic                       rst_in = 1'b1;
  logic                       ext_level = 1'b1;
  logic                       copy_cmd_in = 1'b0;
  logic [7:0]                 control_nv_in = 8'h40;
  gauge_regs_pkg::meas_type   meas;
  gauge_regs_pkg::thresh_type thr;
  gauge_regs_pkg::event_type  ev = '0;
  logic                       scl, host_sda, sda_oe, pin_oe, sleep, ack;
  logic [7:0]                 status, control, nv_out, q;
  logic [6:0]                 slave;
  wire                        sda_line = host_sda & ~sda_oe;
  wire                        pin_line = ~pin_oe & ext_level;
  int                         mismatches = 0;
  int                         n_compared = 0;
  always #12.5 clk_sys_in = ~clk_sys_in;
  gauge_status_control_regs #(.SLEEP_CYCLES(20)) DUT (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_line), .sda_out(), .sda_oe_out(sda_oe),
    .general_purpose_pin_in(pin_line), .general_purpose_pin_out(),
    .general_purpose_pin_oe_out(pin_oe), .meas_in(meas),
    .thresh_in(thr), .event_in(ev), .control_nv_in(control_nv_in),
    .copy_cmd_in(copy_cmd_in), .control_nv_out(nv_out),
    .sleep_out(sleep), .status_out(status), .control_out(control),
    .slave_addr_out(slave));
  host_master host (.clk_in(clk_sys_in), .sda_in(sda_line),
                    .scl_out(scl), .sda_out(host_sda));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ack);
    check({7'h00, ack}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, q);
    check(q, exp);
  endtask
  task automatic flag(input int b, input logic v);
    check({7'h00, status[b]}, {7'h00, v});
  endtask
  task automatic pulse(input logic [3:0] e);
    step(1);
    ev = e;
    step(1);
    ev = '0;
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    meas = '{16'h0BB8, 16'h0BB8, 16'h0000, 16'h0000, 16'h0064, 8'h32, 8'h32};
    thr = '{16'h0FA0, 16'h0032, 16'h07D0, 16'h0064, 16'h05DC};
    step(4);
    rst_in = 1'b0;
    step(4);
    check(control, 8'h40);
    rd(8'h01, 8'h02);
    wr(8'h01, 8'hFF);
    rd(8'h01, 8'h02);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    wr(8'h60, 8'h20);
    copy_cmd_in = 1'b1;
    step(1);
    copy_cmd_in = 1'b0;
    check(nv_out, 8'h20);
    rd(8'h15, 8'h01);
    wr(8'h15, 8'h00);
    check({7'h00, pin_oe}, 8'h01);
    rd(8'h15, 8'h00);
    wr(8'h15, 8'h01);
    ext_level = 1'b0;
    rd(8'h15, 8'h00);
    ext_level = 1'b1;
    rd(8'h15, 8'h01);
    wr(8'h7E, 8'h44);
    check({1'b0, slave}, 8'h34);
    wr(8'h15, 8'h03);
    wr(8'h7E, 8'h44);
    check({1'b0, slave}, 8'h22);
    host.write_reg(8'h15, 8'h00, ack);
    check({7'h00, ack}, 8'h01);
    host.dev_addr = 7'h22;
    rd(8'h7E, 8'h44);
    wr(8'h15, 8'h01);
    meas.standby_relative_capacity = 8'h09;
    step(2);
    flag(5, 1'b1);
    meas.standby_relative_capacity = 8'h0C;
    step(2);
    flag(5, 1'b1);
    meas.standby_relative_capacity = 8'h10;
    step(2);
    flag(5, 1'b0);
    meas.voltage_reading = 16'h076C;
    meas.active_relative_capacity = 8'h04;
    step(2);
    flag(6, 1'b1);
    meas.voltage_reading = 16'h0BB8;
    step(2);
    flag(6, 1'b1);
    meas.active_relative_capacity = 8'h06;
    step(2);
    flag(6, 1'b0);
    meas.voltage_reading = 16'h0578;
    step(2);
    meas.voltage_reading = 16'h0BB8;
    step(2);
    flag(2, 1'b1);
    wr(8'h01, 8'h00);
    rd(8'h01, 8'h00);
    meas = '{16'h1004, 16'h0BB8, 16'h0000, 16'h0000, 16'h0064, 8'h5F, 8'h32};
    for (int i = 0; i < 2; i++)
    begin
      pulse(4'b0010);
      step(4);
      flag(7, 1'b0);
      meas.average_current = 16'h0014;
    end
    pulse(4'b0010);
    pulse(4'b0010);
    flag(7, 1'b1);
    meas.active_relative_capacity = 8'h59;
    step(2);
    flag(7, 1'b0);
    meas = '{16'h0BB8, 16'h0BB8, -16'sh00C8, 16'h0000, 16'h0064, 8'h32, 8'h32};
    pulse(4'b0100);
    pulse(4'b0100);
    pulse(4'b1000);
    meas.voltage_reading = 16'h076C;
    pulse(4'b1000);
    flag(4, 1'b1);
    meas.current_reading = 16'sh00C8;
    meas.voltage_reading = 16'h0BB8;
    step(2);
    flag(4, 1'b1);
    pulse(4'b0001);
    flag(4, 1'b0);
    meas.current_reading = -16'sh0032;
    pulse(4'b0100);
    pulse(4'b0100);
    pulse(4'b1000);
    meas.voltage_reading = 16'h076C;
    pulse(4'b1000);
    flag(4, 1'b0);
    meas.voltage_reading = 16'h0BB8;
    meas.current_reading = 16'h0000;
    wr(8'h15, 8'h00);
    host.lines(1'b0, 1'b0);
    step(40);
    check({7'h00, sleep}, 8'h01);
    check({7'h00, pin_oe}, 8'h00);
    host.lines(1'b1, 1'b1);
    step(4);
    check({7'h00, sleep}, 8'h00);
    rd(8'h15, 8'h01);
    wr(8'h60, 8'h40);
    meas.input_voltage = 16'h0578;
    step(40);
    check({7'h00, sleep}, 8'h01);
    meas.input_voltage = 16'h0BB8;
    host.lines(1'b0, 1'b1);
    host.lines(1'b1, 1'b1);
    check({7'h00, sleep}, 8'h00);
    wr(8'h60, 8'h00);
    meas.input_voltage = 16'h0578;
    step(40);
    check({7'h00, sleep}, 8'h00);
    meas.input_voltage = 16'h0BB8;
    wr(8'h15, 8'h00);
    rst_in = 1'b1;
    step(4);
    rst_in = 1'b0;
    step(4);
    check(status, 8'h02);
    check(control, 8'h40);
    check({7'h00, pin_oe}, 8'h00);
    give_verdict();
  end
endmodule // tb_gauge_status_control_regs
